// [rtl/phy_mgmt_pkg.sv]
// package: register map, field layout, frame timing and reset values for phy management regs
package phy_mgmt_pkg;
  // register indices on the serial management interface
  localparam logic [4:0] IDX_CONTROL    = 5'h00;
  localparam logic [4:0] IDX_STATUS     = 5'h01;
  localparam logic [4:0] IDX_ID_HIGH    = 5'h02;
  localparam logic [4:0] IDX_ID_LOW     = 5'h03;
  // control bit positions
  localparam int CTL_SOFT_RESET  = 15;
  localparam int CTL_LOOPBACK    = 14;
  localparam int CTL_SPEED       = 13;
  localparam int CTL_ANEG_EN     = 12;
  localparam int CTL_POWER_DOWN  = 11;
  localparam int CTL_ISOLATE     = 10;
  localparam int CTL_ANEG_RESTART = 9;
  localparam int CTL_DUPLEX      = 8;
  // control value after reset, before straps are applied
  localparam logic [15:0] CTL_RESET_VAL = 16'h0000;
  // status bit positions
  localparam int STS_ANEG_DONE    = 5;
  localparam int STS_REMOTE_FAULT = 4;
  localparam int STS_LINK         = 2;
  localparam int STS_JABBER       = 1;
  // constant status bits: no t4, four abilities, aneg able, extended regs
  localparam logic [15:0] STS_FIXED_VAL  = 16'h7809;
  localparam logic [15:0] STS_FIXED_MASK = 16'hF809;
  // identifier layout
  localparam int ID_OUI_LSB   = 10;
  localparam int ID_MODEL_LSB = 4;
  // management frame counts
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [4:0] HDR_BITS      = 5'h0D;
  localparam logic [4:0] DATA_BITS     = 5'h10;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  // strap capture point after reset release (two sync stages)
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
  // software reset duration
  localparam int CLK_PERIOD_NS   = 25;
  localparam int SOFT_RST_TIME_NS = 500;
  localparam int SOFT_RST_CYCLES =
    (SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // frame receiver states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_HDR  = 4'h2,
    ST_TA   = 4'h4,
    ST_DATA = 4'h8
  } frame_state_e;
  // effective operating configuration handed to the transceiver core
  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic aneg_en;
    logic power_down;
    logic isolate;
    logic full_duplex;
  } phy_cfg_s;
endpackage

// [rtl/phy_basic_mgmt_registers.sv]
// module: basic control, status and identifier registers behind a serial management slave
//
// Contract
// - control bit 15 starts soft reset, self-clears
// - soft reset keeps register values, ignores straps
// - control bit 14 selects loopback mode
// - bit 13 picks speed unless autoneg
// - bit 12 enables autoneg, overriding speed/duplex
// - bit 10 isolates from the rmii
// - bit 9 restarts autoneg, self-clears
// - bit 8 picks duplex unless autoneg
// - straps seed speed/aneg/duplex; others reset zero
// - status ability bits read fixed values
// - status bit 5 shows autoneg complete
// - status bit 4 remote fault latch-high
// - status bit 2 link latch-low
// - status bit 1 jabber latch-high
// - identifier high holds oui bits 3-18
// - identifier low: oui, model, revision
// - revision reset value from silicon revision
// - latch-high holds until read, then follows
// - latch-low holds zero until read
// - registers at indices 0,1,2,3
`timescale 1ns/1ps
module phy_basic_mgmt_registers #(
  parameter logic [15:0] OUI_HIGH_VAL = 16'h1234, // arbitrary value
  parameter logic [5:0]  OUI_LOW_VAL  = 6'h15,    // arbitrary value
  parameter logic [5:0]  MODEL_VAL    = 6'h2A     // arbitrary value
) (
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  input  wire logic                     mdc,
  input  wire logic                     mdio_in,
  output logic                          mdio_out,
  output logic                          mdio_oe,
  input  wire logic [4:0]               phy_addr,
  input  wire logic                     strap_speed_100,
  input  wire logic                     strap_aneg_en,
  input  wire logic                     strap_full_duplex,
  input  wire logic [3:0]               silicon_rev,
  input  wire logic                     aneg_done,
  input  wire logic                     aneg_speed_100,
  input  wire logic                     aneg_full_duplex,
  input  wire logic                     remote_fault,
  input  wire logic                     link_up,
  input  wire logic                     jabber,
  output phy_mgmt_pkg::phy_cfg_s        cfg,
  output logic                          aneg_restart,
  output logic                          soft_reset
);
  import phy_mgmt_pkg::*;

  // pin synchronisers: stage one feeds stage two only
  logic [2:0]  mdc_sync_reg;     // mdc stages, bit 2 kept for edge detect
  logic [1:0]  mdio_sync_reg;    // mdio stages
  logic [4:0]  addr_s1_reg;      // phy address stage one
  logic [4:0]  addr_s2_reg;      // phy address stage two
  logic [6:0]  strap_s1_reg;     // straps and revision, stage one
  logic [6:0]  strap_s2_reg;     // straps and revision, stage two
  logic [1:0]  strap_cnt_reg;    // cycles since reset release
  // registers
  logic [15:0] ctrl_reg;         // control, bits 7:0 unused
  logic [15:0] ctrl_next;        // control next value
  logic [15:0] id_high_reg;      // identifier high
  logic [15:0] id_low_reg;       // identifier low
  logic        rf_held_reg;      // latched remote fault
  logic        jab_held_reg;     // latched jabber
  logic        link_held_reg;    // latched link status
  logic [4:0]  sr_cnt_reg;       // soft reset duration counter
  // frame receiver
  frame_state_e state_reg;       // receiver state
  logic [5:0]  pre_cnt_reg;      // consecutive preamble ones
  logic [4:0]  bit_cnt_reg;      // bits within current field
  logic [15:0] shift_reg;        // header and write data shifter
  logic [15:0] rdata_reg;        // read snapshot being shifted out
  logic        is_read_reg;      // current frame is a read
  logic [4:0]  regad_reg;        // register index of the frame

  // decode wires
  wire         mdc_rise    = mdc_sync_reg[1] & ~mdc_sync_reg[2];
  wire         mdio_s      = mdio_sync_reg[1];
  wire         strap_load  = (strap_cnt_reg == STRAP_LOAD_CNT);
  wire [15:0]  hdr_word    = {shift_reg[14:0], mdio_s};
  wire         hdr_last    = (state_reg == ST_HDR) && mdc_rise
                             && (bit_cnt_reg == HDR_BITS - 5'h01);
  wire         hdr_ok      = hdr_word[12] && (hdr_word[9:5] == addr_s2_reg)
                             && (hdr_word[11:10] == OP_READ || hdr_word[11:10] == OP_WRITE);
  wire         rd_take     = hdr_last && hdr_ok && (hdr_word[11:10] == OP_READ);
  wire         rd_status   = rd_take && (hdr_word[4:0] == IDX_STATUS);
  wire         wr_commit   = (state_reg == ST_DATA) && mdc_rise && !is_read_reg
                             && (bit_cnt_reg == DATA_BITS - 5'h01);
  wire [15:0]  wdata       = hdr_word;
  wire         wr_ctrl     = wr_commit && (regad_reg == IDX_CONTROL);
  wire         wr_id_high  = wr_commit && (regad_reg == IDX_ID_HIGH);
  wire         wr_id_low   = wr_commit && (regad_reg == IDX_ID_LOW);
  wire         sr_done     = ctrl_reg[CTL_SOFT_RESET]
                             && (sr_cnt_reg == 5'(SOFT_RST_CYCLES - 1));
  // status word assembled from fixed and live bits
  wire [15:0]  status_word = STS_FIXED_VAL
                             | (16'(aneg_done)     << STS_ANEG_DONE)
                             | (16'(rf_held_reg)   << STS_REMOTE_FAULT)
                             | (16'(link_held_reg) << STS_LINK)
                             | (16'(jab_held_reg)  << STS_JABBER);
  // register read mux; unmapped indices read zero
  function automatic logic [15:0] reg_read(input logic [4:0] idx);
    unique case (idx)
      IDX_CONTROL: reg_read = {ctrl_reg[15:8], 8'h00};
      IDX_STATUS:  reg_read = status_word;
      IDX_ID_HIGH: reg_read = id_high_reg;
      IDX_ID_LOW:  reg_read = id_low_reg;
      default:     reg_read = 16'h0000;
    endcase
  endfunction
  // synchronise all pins and straps coming from outside
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mdc_sync_reg  <= 3'h0;
      mdio_sync_reg <= 2'h0;
      addr_s1_reg   <= 5'h00;
      addr_s2_reg   <= 5'h00;
      strap_s1_reg  <= 7'h00;
      strap_s2_reg  <= 7'h00;
    end else begin
      mdc_sync_reg  <= {mdc_sync_reg[1:0], mdc};
      mdio_sync_reg <= {mdio_sync_reg[0], mdio_in};
      addr_s1_reg   <= phy_addr;
      addr_s2_reg   <= addr_s1_reg;
      strap_s1_reg  <= {strap_speed_100, strap_aneg_en, strap_full_duplex, silicon_rev};
      strap_s2_reg  <= strap_s1_reg;
    end
  end
  // strap capture happens once, a fixed count after release; soft reset never reloads
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      strap_cnt_reg <= 2'h0;
    end else if (strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end
  // control next value: writes, self-clears, strap seeding
  always_comb begin
    ctrl_next = ctrl_reg;
    if (sr_done) begin
      ctrl_next[CTL_SOFT_RESET] = 1'b0;
    end
    if (ctrl_reg[CTL_ANEG_RESTART]) begin
      ctrl_next[CTL_ANEG_RESTART] = 1'b0;
    end
    if (wr_ctrl) begin
      // a zero written to a self-clearing bit has no effect
      ctrl_next[14:10] = wdata[14:10];
      ctrl_next[CTL_DUPLEX] = wdata[CTL_DUPLEX];
      ctrl_next[CTL_ANEG_RESTART] = ctrl_next[CTL_ANEG_RESTART] | wdata[CTL_ANEG_RESTART];
      ctrl_next[CTL_SOFT_RESET] = ctrl_next[CTL_SOFT_RESET] | wdata[CTL_SOFT_RESET];
    end
    if (strap_load) begin
      ctrl_next[CTL_SPEED]   = strap_s2_reg[6];
      ctrl_next[CTL_ANEG_EN] = strap_s2_reg[5];
      ctrl_next[CTL_DUPLEX]  = strap_s2_reg[4];
    end
    ctrl_next[7:0] = 8'h00;
  end
  // control and identifier registers; soft reset leaves them as they are
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl_reg    <= CTL_RESET_VAL;
      id_high_reg <= OUI_HIGH_VAL;
      id_low_reg  <= {OUI_LOW_VAL, MODEL_VAL, 4'h0};
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr_id_high) begin
        id_high_reg <= wdata;
      end
      if (strap_load) begin
        id_low_reg[3:0] <= strap_s2_reg[3:0];
      end else if (wr_id_low) begin
        id_low_reg <= wdata;
      end
    end
  end

  // soft reset timer
  always_ff @(posedge mclk) begin
    if (!reset_n || !ctrl_reg[CTL_SOFT_RESET]) begin
      sr_cnt_reg <= 5'h00;
    end else if (!sr_done) begin
      sr_cnt_reg <= sr_cnt_reg + 5'h01;
    end
  end

  // latched status; the event wins over a read release in the same cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rf_held_reg   <= 1'b0;
      jab_held_reg  <= 1'b0;
      link_held_reg <= 1'b0;
    end else begin
      rf_held_reg   <= remote_fault | (rf_held_reg & ~rd_status);
      jab_held_reg  <= jabber | (jab_held_reg & ~rd_status);
      link_held_reg <= link_up & (link_held_reg | rd_status);
    end
  end

  // effective configuration and strobes, all from flops
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cfg          <= '0;
      aneg_restart <= 1'b0;
      soft_reset   <= 1'b0;
    end else begin
      cfg.loopback    <= ctrl_reg[CTL_LOOPBACK];
      cfg.aneg_en     <= ctrl_reg[CTL_ANEG_EN];
      cfg.power_down  <= ctrl_reg[CTL_POWER_DOWN];
      cfg.isolate     <= ctrl_reg[CTL_ISOLATE];
      // negotiation result overrides the manual choices
      cfg.speed_100   <= ctrl_reg[CTL_ANEG_EN] ? aneg_speed_100
                                               : ctrl_reg[CTL_SPEED];
      cfg.full_duplex <= ctrl_reg[CTL_ANEG_EN] ? aneg_full_duplex
                                               : ctrl_reg[CTL_DUPLEX];
      aneg_restart    <= ctrl_reg[CTL_ANEG_RESTART];
      soft_reset      <= ctrl_reg[CTL_SOFT_RESET];
    end
  end

  // management frame receiver; everything moves on a synced mdc rise
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg   <= ST_IDLE;
      pre_cnt_reg <= 6'h00;
      bit_cnt_reg <= 5'h00;
      shift_reg   <= 16'h0000;
      rdata_reg   <= 16'h0000;
      is_read_reg <= 1'b0;
      regad_reg   <= 5'h00;
      mdio_out    <= 1'b0;
      mdio_oe     <= 1'b0;
    end else if (mdc_rise) begin
      unique case (state_reg)
        ST_IDLE: begin
          // start bit zero only counts after a full preamble
          if (mdio_s) begin
            if (pre_cnt_reg != PREAMBLE_BITS) begin
              pre_cnt_reg <= pre_cnt_reg + 6'h01;
            end
          end else begin
            if (pre_cnt_reg == PREAMBLE_BITS) begin
              state_reg <= ST_HDR;
            end
            pre_cnt_reg <= 6'h00;
          end
          bit_cnt_reg <= 5'h00;
          shift_reg   <= 16'h0000;
        end
        ST_HDR: begin
          shift_reg   <= hdr_word;
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (hdr_last) begin
            bit_cnt_reg <= 5'h00;
            regad_reg   <= hdr_word[4:0];
            is_read_reg <= rd_take;
            rdata_reg   <= reg_read(hdr_word[4:0]);
            // foreign address or bad opcode: stay silent, wait for preamble
            state_reg   <= hdr_ok ? ST_TA : ST_IDLE;
          end
        end
        ST_TA: begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == 5'h00) begin
            // second turnaround bit is driven low on a read
            mdio_out <= 1'b0;
            mdio_oe  <= is_read_reg;
          end else begin
            state_reg   <= ST_DATA;
            bit_cnt_reg <= 5'h00;
            mdio_out    <= rdata_reg[15] & is_read_reg;
            rdata_reg   <= {rdata_reg[14:0], 1'b0};
          end
        end
        ST_DATA: begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          shift_reg   <= hdr_word;
          mdio_out    <= rdata_reg[15] & is_read_reg;
          rdata_reg   <= {rdata_reg[14:0], 1'b0};
          if (bit_cnt_reg == DATA_BITS - 5'h01) begin
            state_reg <= ST_IDLE;
            mdio_out  <= 1'b0;
            mdio_oe   <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          mdio_oe   <= 1'b0;
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_sr_start;
    $rose(ctrl_reg[CTL_SOFT_RESET]);
  endsequence
  sequence s_sr_end;
    ##[18:22] !ctrl_reg[CTL_SOFT_RESET];
  endsequence
  a_soft_reset_ends: assert property (s_sr_start |-> s_sr_end)
    else $error("soft reset bit did not self-clear on time");
  a_soft_reset_out: assert property (ctrl_reg[CTL_SOFT_RESET] |=> soft_reset)
    else $error("soft reset output not asserted");
  a_loopback_cfg: assert property (##1 cfg.loopback == $past(ctrl_reg[CTL_LOOPBACK]))
    else $error("loopback does not follow control");
  a_speed_manual: assert property (!ctrl_reg[CTL_ANEG_EN] |=>
    cfg.speed_100 == $past(ctrl_reg[CTL_SPEED])) else $error("manual speed not applied");
  a_duplex_aneg: assert property (ctrl_reg[CTL_ANEG_EN] |=>
    cfg.full_duplex == $past(aneg_full_duplex)) else $error("negotiated duplex not applied");
  a_isolate_cfg: assert property (ctrl_reg[CTL_ISOLATE] |=> cfg.isolate)
    else $error("isolate not applied");
  a_restart_pulse: assert property (ctrl_reg[CTL_ANEG_RESTART] && !wr_ctrl |=>
    !ctrl_reg[CTL_ANEG_RESTART] ##0 aneg_restart) else $error("restart did not pulse once");
  a_strap_seed: assert property (strap_load |=>
    ctrl_reg[CTL_ANEG_EN] == $past(strap_s2_reg[5]) && id_low_reg[3:0] == $past(strap_s2_reg[3:0]))
    else $error("strap values not seeded");
  a_status_fixed: assert property (rd_status |=>
    (rdata_reg & STS_FIXED_MASK) == STS_FIXED_VAL) else $error("fixed status bits wrong");
  a_aneg_done_bit: assert property (rd_status |=>
    rdata_reg[STS_ANEG_DONE] == $past(aneg_done)) else $error("aneg complete bit wrong");
  a_fault_latch: assert property (remote_fault |=> rf_held_reg ##1
    (rf_held_reg || $past(rd_status) || $past(remote_fault))) else $error("fault not latched");
  a_jabber_hold: assert property (jab_held_reg && !rd_status |=> jab_held_reg)
    else $error("jabber latch dropped without read");
  a_link_low: assert property (!link_up |=> !link_held_reg ##1
    (!link_held_reg || $past(rd_status))) else $error("link drop not latched low");
  a_link_release: assert property (rd_status && link_up |=> link_held_reg)
    else $error("link not released by read");
endmodule

// [dv/mdio_host_model.sv]
// station management host model: drives serial management frames on mdc and mdio
`timescale 1ns/1ps
module mdio_host_model
  import phy_mgmt_pkg::*;
(
  input  wire logic mclk,
  input  wire logic mdio_wire,
  input  wire logic mdio_oe,
  output logic      mdc,
  output logic      host_oe,
  output logic      host_val
);
  logic seen_oe; // device drove the line during the last frame

  // management clock stands low between frames
  initial begin
    mdc = 1'b0;
    host_oe = 1'b0;
    host_val = 1'b0;
    seen_oe = 1'b0;
  end

  // one whole frame, ten mclk per mdc period; samples just before each mdc rise
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd, output logic ta_low);
    logic [63:0] bits;
    logic        rel;
    bits = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    ta_low = 1'b0;
    seen_oe = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      // on a read the host lets go for turnaround and data
      rel = (op == OP_READ) && (i <= 17);
      @(negedge mclk);
      mdc = 1'b0;
      host_oe = !rel;
      host_val = bits[i];
      repeat (4) @(negedge mclk);
      if (i <= 15)
        rd[i] = mdio_wire;
      if (i == 16)
        ta_low = (mdio_wire === 1'b0);
      if (mdio_oe === 1'b1)
        seen_oe = 1'b1;
      @(negedge mclk);
      mdc = 1'b1;
      repeat (4) @(negedge mclk);
    end
    // release the line; the pull-up takes it high
    @(negedge mclk);
    mdc = 1'b0;
    host_oe = 1'b0;
    repeat (6) @(negedge mclk);
  endtask
endmodule

// [dv/phy_basic_mgmt_registers_tb.sv]
// self-checking bench for the basic management register block
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module phy_basic_mgmt_registers_tb;
  import phy_mgmt_pkg::*;
  localparam logic [15:0] OUI_H = 16'h4A5B; // arbitrary value
  localparam logic [5:0]  OUI_L = 6'h0C;    // arbitrary value
  localparam logic [5:0]  MODEL = 6'h21;    // arbitrary value
  localparam logic [4:0]  ADDR  = 5'h03;    // our device address
  localparam logic [15:0] STS   = STS_FIXED_VAL | 16'h0024; // link up, negotiation done
  logic        mclk, reset_n, mdc, mdio_in, mdio_out, mdio_oe, host_oe, host_val;
  logic        strap_speed_100, strap_aneg_en, strap_full_duplex, aneg_restart, soft_reset;
  logic        aneg_done, aneg_speed_100, aneg_full_duplex, remote_fault, link_up, jabber;
  logic [3:0]  silicon_rev;
  logic [15:0] rdat;
  logic        ta;
  phy_cfg_s    cfg;
  int          n_mismatch, n_checks, n_srst, n_restart, i;

  // open-drain style line: device, then host, else pull-up
  assign mdio_in = (mdio_oe === 1'b1) ? mdio_out : (host_oe ? host_val : 1'b1);

  phy_basic_mgmt_registers #(.OUI_HIGH_VAL(OUI_H), .OUI_LOW_VAL(OUI_L), .MODEL_VAL(MODEL))
    phy_basic_mgmt_registers_inst (
    .mclk(mclk), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr(ADDR), .strap_speed_100(strap_speed_100),
    .strap_aneg_en(strap_aneg_en), .strap_full_duplex(strap_full_duplex),
    .silicon_rev(silicon_rev), .aneg_done(aneg_done), .aneg_speed_100(aneg_speed_100),
    .aneg_full_duplex(aneg_full_duplex), .remote_fault(remote_fault), .link_up(link_up),
    .jabber(jabber), .cfg(cfg), .aneg_restart(aneg_restart), .soft_reset(soft_reset));

  mdio_host_model host_inst (
    .mclk(mclk), .mdio_wire(mdio_in), .mdio_oe(mdio_oe), .mdc(mdc), .host_oe(host_oe),
    .host_val(host_val));

  // 40 MHz system clock
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // pulse widths of the self-clearing actions
  always @(posedge mclk) begin
    if (soft_reset === 1'b1)
      n_srst++;
    if (aneg_restart === 1'b1)
      n_restart++;
  end

  // read a register and compare, turnaround included
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    host_inst.xfer(OP_READ, ADDR, ra, 16'h0000, rdat, ta);
    `CHK(ta, 1'b1)
    `CHK(rdat, exp)
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    host_inst.xfer(OP_WRITE, ADDR, ra, d, rdat, ta);
  endtask

  // verdict and end of run
  task automatic results();
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    n_mismatch = 0;
    n_checks = 0;
    n_srst = 0;
    n_restart = 0;
    reset_n = 1'b0;
    strap_speed_100 = 1'b1;
    strap_aneg_en = 1'b1;
    strap_full_duplex = 1'b0;
    silicon_rev = 4'h5;
    aneg_done = 1'b0;
    aneg_speed_100 = 1'b0;
    aneg_full_duplex = 1'b1;
    remote_fault = 1'b0;
    link_up = 1'b1;
    jabber = 1'b0;
    repeat (20) @(negedge mclk);
    reset_n = 1'b1;
    repeat (10) @(negedge mclk);
    // revision changes later must not reach the captured field
    silicon_rev = 4'hA;
    rd(IDX_CONTROL, 16'h3000);
    `CHK(cfg, 6'h09)
    rd(IDX_ID_HIGH, OUI_H);
    rd(IDX_ID_LOW, {OUI_L, MODEL, 4'h5});
    wr(IDX_ID_LOW, 16'h3079);
    rd(IDX_ID_LOW, 16'h3079);
    wr(IDX_ID_HIGH, 16'hC3A5);
    rd(IDX_ID_HIGH, 16'hC3A5);
    // manual mode: loopback, 100M, isolate, full duplex
    wr(IDX_CONTROL, 16'h6500);
    rd(IDX_CONTROL, 16'h6500);
    `CHK(cfg, 6'h33)
    // negotiation already off, so power down is legal; reserved bits read zero
    wr(IDX_CONTROL, 16'h08FF);
    rd(IDX_CONTROL, 16'h0800);
    `CHK(cfg, 6'h04)
    n_restart = 0;
    wr(IDX_CONTROL, 16'h3300);
    `CHK(n_restart, 1)
    rd(IDX_CONTROL, 16'h3100);
    `CHK(cfg, 6'h09)
    // soft reset written alone; straps must not come back
    n_srst = 0;
    wr(IDX_CONTROL, 16'h8000);
    for (i = 0; i < 100 && soft_reset !== 1'b0; i++)
      @(negedge mclk);
    if (i == 100) begin
      n_mismatch++;
      results();
    end
    `CHK(n_srst >= SOFT_RST_CYCLES && n_srst <= SOFT_RST_CYCLES + 1, 1'b1)
    rd(IDX_CONTROL, 16'h0000);
    `CHK(cfg, 6'h00)
    // link bit latched low since reset; this first read shows it and releases it
    rd(IDX_STATUS, STS & 16'hFFDB);
    rd(IDX_STATUS, STS & 16'hFFDF);
    aneg_done = 1'b1;
    rd(IDX_STATUS, STS);
    // short fault pulses, gone before the read
    for (i = 0; i < 2; i++) begin
      remote_fault = (i == 0);
      jabber = (i == 1);
      repeat (3) @(negedge mclk);
      remote_fault = 1'b0;
      jabber = 1'b0;
      rd(IDX_STATUS, STS | ((i == 0) ? 16'h0010 : 16'h0002));
      rd(IDX_STATUS, STS);
    end
    // a lasting condition survives the read, then holds until the next read
    jabber = 1'b1;
    rd(IDX_STATUS, STS | 16'h0002);
    rd(IDX_STATUS, STS | 16'h0002);
    jabber = 1'b0;
    rd(IDX_STATUS, STS | 16'h0002);
    rd(IDX_STATUS, STS);
    link_up = 1'b0;
    repeat (3) @(negedge mclk);
    link_up = 1'b1;
    rd(IDX_STATUS, STS & 16'hFFFB);
    rd(IDX_STATUS, STS);
    // status is read-only, index 5 is unmapped
    wr(IDX_STATUS, 16'h0000);
    rd(IDX_STATUS, STS);
    rd(5'h05, 16'h0000);
    // another station address: no drive, pull-up seen
    host_inst.xfer(OP_READ, ADDR ^ 5'h01, IDX_STATUS, 16'h0000, rdat, ta);
    `CHK(host_inst.seen_oe, 1'b0)
    `CHK(rdat, 16'hFFFF)
    `CHK(mdio_oe, 1'b0)
    // opcode 11 is refused: no drive and control left as it is
    host_inst.xfer(2'h3, ADDR, IDX_CONTROL, 16'h4000, rdat, ta);
    `CHK(host_inst.seen_oe, 1'b0)
    rd(IDX_CONTROL, 16'h0000);
    results();
  end
endmodule
